// ---- rtl/adc_ctrl.sv ----
// Converter control: configuration, sequencing and result registers.
// Assumes an Avalon-MM master on clk and a front end whose left-aligned
// sample on raw_sample is synchronous to clk and valid at each tick.
//
// Functional notes
// - Result is read-only signed 16 bits, upper zero
// - Result left-aligned, top valid bit is 15
// - Period field gives 32 shl n clocks
// - Positive select codes map pins and references
// - Negative select uses same code map
// - Clock select: zero fast, one slow
// - Enable one runs continuously, zero stops
// - First conversion doubled plus 21 us
// - Config change while running doubles next conversion
// - Offset added, then gain applied to result
`timescale 1ns/1ps
module adc_ctrl (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [31:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [15:0] raw_sample,
    output logic             converter_run,
    output logic             conv_clk_en,
    output logic             sample_done,
    output logic             slow_clock_select,
    output logic      [3:0]  positive_input_select,
    output logic      [3:0]  negative_input_select,
    output logic             select_reserved
);

    localparam int CW = adc_ctrl_pkg::COUNT_W;
    localparam int SW = adc_ctrl_pkg::SETTLE_W;

    adc_ctrl_pkg::config_t     cfg_q;
    adc_ctrl_pkg::config_t     cfg_d;
    adc_ctrl_pkg::conv_state_t state_q;
    adc_ctrl_pkg::conv_state_t state_d;
    logic [15:0]   offset_q;
    logic [15:0]   offset_d;
    logic [15:0]   gain_q;
    logic [15:0]   gain_d;
    logic [15:0]   result_q;
    logic [15:0]   result_d;
    logic [2:0]    per_q;
    logic [2:0]    per_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [SW-1:0] settle_q;
    logic [SW-1:0] settle_d;
    logic          double_q;
    logic          double_d;
    logic          done_q;
    logic          done_d;
    logic          ack_q;
    logic          ack_d;
    logic [31:0]   rdata_q;
    logic [31:0]   rdata_d;
    logic          wr_en;
    logic          cfg_changed;
    logic          tick;
    logic [CW-1:0] target;
    logic [15:0]   corrected;

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [15:0] v;
        v = old;
        for (int i = 0; i < 2; i++) begin
            if (be[i]) begin
                v[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return v;
    endfunction

    // Converter clock enable, fast or slow
    conv_tick_gen u_tick (
        .clk    (clk),
        .reset  (reset),
        .enable (state_q != adc_ctrl_pkg::ST_IDLE),
        .slow   (cfg_q.slow_clock_select),
        .tick   (tick)
    );

    // Offset then gain on the sample, masked to resolution
    result_correct u_correct (
        .raw    (raw_sample),
        .offset (offset_q),
        .gain   (gain_q),
        .period (cfg_q.period),
        .value  (corrected)
    );

    // Bus slave: one wait cycle, then the request completes
    always_comb begin
        ack_d   = (read | write) & ~ack_q;
        wr_en   = write & ack_q;
        rdata_d = rdata_q;
        if (read && !ack_q) begin
            case (address)
                adc_ctrl_pkg::RESULT_ADDR: rdata_d = {16'h0000, result_q};
                adc_ctrl_pkg::CONFIG_ADDR: rdata_d = {16'h0000, cfg_q};
                adc_ctrl_pkg::OFFSET_ADDR: rdata_d = {16'h0000, offset_q};
                adc_ctrl_pkg::GAIN_ADDR:   rdata_d = {16'h0000, gain_q};
                default:                   rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Register writes; the result register ignores writes
    always_comb begin
        cfg_d    = cfg_q;
        offset_d = offset_q;
        gain_d   = gain_q;
        if (wr_en && address == adc_ctrl_pkg::CONFIG_ADDR) begin
            cfg_d = merge16(cfg_q, writedata, byteenable);
        end
        if (wr_en && address == adc_ctrl_pkg::OFFSET_ADDR) begin
            offset_d = merge16(offset_q, writedata, byteenable);
        end
        if (wr_en && address == adc_ctrl_pkg::GAIN_ADDR) begin
            gain_d = merge16(gain_q, writedata, byteenable);
        end
        cfg_changed = (cfg_d != cfg_q);
    end

    // Conversion length in converter clocks, doubled when flagged
    always_comb begin
        target = CW'(adc_ctrl_pkg::BASE_CLOCKS) << cfg_q.period;
        if (double_q) begin
            target = target << 1;
        end
    end

    // Sequencer: settle after start, then back-to-back conversions
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        settle_d = settle_q;
        double_d = double_q;
        done_d   = 1'b0;
        result_d = result_q;
        per_d    = per_q;
        case (state_q)
            adc_ctrl_pkg::ST_IDLE: begin
                if (cfg_q.enable) begin
                    state_d  = adc_ctrl_pkg::ST_SETTLE;
                    settle_d = '0;
                    cnt_d    = '0;
                    double_d = 1'b1;
                end
            end
            adc_ctrl_pkg::ST_SETTLE: begin
                if (settle_q == SW'(adc_ctrl_pkg::SETTLE_CYC - 1)) begin
                    state_d = adc_ctrl_pkg::ST_CONVERT;
                end else begin
                    settle_d = settle_q + SW'(1);
                end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
                if (tick) begin
                    if (cnt_q == target - CW'(1)) begin
                        cnt_d    = '0;
                        double_d = 1'b0;
                        done_d   = 1'b1;
                        result_d = corrected;
                        per_d    = cfg_q.period;
                    end else begin
                        cnt_d = cnt_q + CW'(1);
                    end
                end
            end
            default: begin
                state_d = adc_ctrl_pkg::ST_IDLE;
            end
        endcase
        if (!cfg_q.enable) begin
            state_d  = adc_ctrl_pkg::ST_IDLE;
            double_d = 1'b0;
        end else if (cfg_changed && cfg_d.enable &&
                     state_q == adc_ctrl_pkg::ST_CONVERT) begin
            cnt_d    = '0;
            double_d = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_q    <= adc_ctrl_pkg::CONFIG_RESET;
            offset_q <= adc_ctrl_pkg::OFFSET_RESET;
            gain_q   <= adc_ctrl_pkg::GAIN_RESET;
            result_q <= adc_ctrl_pkg::RESULT_RESET;
            state_q  <= adc_ctrl_pkg::ST_IDLE;
            per_q    <= 3'h0;
            cnt_q    <= '0;
            settle_q <= '0;
            double_q <= 1'b0;
            done_q   <= 1'b0;
            ack_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            cfg_q    <= cfg_d;
            offset_q <= offset_d;
            gain_q   <= gain_d;
            result_q <= result_d;
            state_q  <= state_d;
            per_q    <= per_d;
            cnt_q    <= cnt_d;
            settle_q <= settle_d;
            double_q <= double_d;
            done_q   <= done_d;
            ack_q    <= ack_d;
            rdata_q  <= rdata_d;
        end
    end

    // Outputs; mux codes go straight to the analog switches
    assign waitrequest           = (read | write) & ~ack_q;
    assign readdata              = rdata_q;
    assign converter_run         = (state_q != adc_ctrl_pkg::ST_IDLE);
    assign conv_clk_en           = tick;
    assign sample_done           = done_q;
    assign slow_clock_select     = cfg_q.slow_clock_select;
    assign positive_input_select = cfg_q.positive_input_select;
    assign negative_input_select = cfg_q.negative_input_select;
    // Flags a reserved code left in either select field
    assign select_reserved =
        !adc_ctrl_pkg::select_valid(cfg_q.positive_input_select) ||
        !adc_ctrl_pkg::select_valid(cfg_q.negative_input_select);

    // Checks on the sequencer and register file
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    result_upper_a: assert property (
        (read && !ack_q && address == adc_ctrl_pkg::RESULT_ADDR)
        |=> (readdata[31:16] == 16'h0000 &&
             readdata[15:0] == $past(result_q)))
        else $error("result read not zero-extended");

    left_align_a: assert property (
        done_q |-> (result_q & ~adc_ctrl_pkg::resolution_mask(per_q))
                   == 16'h0000)
        else $error("result bits below resolution set");

    conv_length_a: assert property (
        (state_q == adc_ctrl_pkg::ST_CONVERT && tick &&
         cnt_q == target - CW'(1) && cfg_q.enable && !cfg_changed)
        |=> done_q && cnt_q == '0)
        else $error("conversion did not end at its length");

    mux_codes_a: assert property (
        $changed(cfg_q) |-> positive_input_select == cfg_q[10:7] &&
                            negative_input_select == cfg_q[6:3])
        else $error("select outputs not from config fields");

    slow_tick_a: assert property (
        (tick && converter_run && $past(cfg_q.slow_clock_select))
        |=> (!tick || !$past(cfg_q.slow_clock_select)) [*8])
        else $error("slow converter clock faster than 1 MHz");

    stop_idle_a: assert property (
        !cfg_q.enable |=> state_q == adc_ctrl_pkg::ST_IDLE)
        else $error("conversions did not stop");

    first_double_a: assert property (
        (state_q == adc_ctrl_pkg::ST_IDLE && cfg_q.enable)
        |=> state_q == adc_ctrl_pkg::ST_SETTLE && double_q)
        else $error("start did not enter doubled settle");

    settle_len_a: assert property (
        $rose(state_q == adc_ctrl_pkg::ST_CONVERT)
        |-> $past(settle_q) == SW'(adc_ctrl_pkg::SETTLE_CYC - 1))
        else $error("settle time not 21 us");

    reconfig_a: assert property (
        (state_q == adc_ctrl_pkg::ST_CONVERT && cfg_changed && cfg_d.enable)
        |=> double_q && cnt_q == '0)
        else $error("reconfiguration did not double next conversion");

    hold_stop_a: assert property (
        state_q == adc_ctrl_pkg::ST_IDLE |=> $stable(result_q))
        else $error("result changed while stopped");

    first_done_c: cover property (
        $rose(state_q == adc_ctrl_pkg::ST_CONVERT) ##[1:1000] done_q);
    reconfig_c: cover property (
        state_q == adc_ctrl_pkg::ST_CONVERT && cfg_changed && cfg_d.enable);
    slow_done_c: cover property (done_q && cfg_q.slow_clock_select);
    stop_c: cover property ($fell(converter_run));

endmodule // adc_ctrl

// ---- rtl/adc_ctrl_pkg.sv ----
// Shared constants and types for the converter control block.
// Assumes a 10 MHz system clock and a byte-addressed 32-bit register bus.
package adc_ctrl_pkg;

    // Register byte addresses
    localparam logic [31:0] RESULT_ADDR = 32'h4000_e000;
    localparam logic [31:0] CONFIG_ADDR = 32'h4000_e004;
    localparam logic [31:0] OFFSET_ADDR = 32'h4000_e008;
    localparam logic [31:0] GAIN_ADDR   = 32'h4000_e00c;

    // Reset values
    localparam logic [15:0] CONFIG_RESET = 16'h1800;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET   = 16'h8000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // Input select codes; pins occupy 0 up to the last pin code
    localparam logic [3:0] SEL_LAST_PIN = 4'h5;
    localparam logic [3:0] SEL_GROUND   = 4'h8;
    localparam logic [3:0] SEL_HALF_PAD = 4'hb;

    // Timing: converter clocks at period zero, rates, start settling
    localparam int BASE_CLOCKS = 32;
    localparam int MIN_BITS    = 7;
    localparam int CLK_MHZ     = 10;
    localparam int FAST_MHZ    = 6;
    localparam int SLOW_MHZ    = 1;
    localparam int SETTLE_US   = 21;
    localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;
    localparam int SETTLE_W    = $clog2(SETTLE_CYC + 1);
    localparam int COUNT_W     = 14;
    localparam int GAIN_FRAC   = 15;

    // Configuration register layout, bit 15 down to bit 0
    typedef struct packed {
        logic [2:0] period;
        logic [1:0] reserved_pair;
        logic [3:0] positive_input_select;
        logic [3:0] negative_input_select;
        logic       slow_clock_select;
        logic       reserved_single;
        logic       enable;
    } config_t;

    // Conversion sequencer states, Gray along idle-settle-convert
    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_SETTLE  = 2'h1,
        ST_CONVERT = 2'h3
    } conv_state_t;

    // Bits of the left-aligned result that carry significance
    function automatic logic [15:0] resolution_mask(input logic [2:0] period);
        return 16'hffff << (4'(16 - MIN_BITS) - {1'b0, period});
    endfunction

    // True for codes that name a real source
    function automatic logic select_valid(input logic [3:0] code);
        return (code <= SEL_LAST_PIN) ||
               (code >= SEL_GROUND && code <= SEL_HALF_PAD);
    endfunction

endpackage

// ---- rtl/conv_tick_gen.sv ----
// Converter clock enable made from the system clock by a fractional divider.
// Assumes the system clock rate in MHz exceeds the fast converter rate.
`timescale 1ns/1ps
module conv_tick_gen (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic slow,
    output logic      tick
);
    logic [3:0] acc_q;
    logic [3:0] acc_d;
    logic       tick_q;
    logic       tick_d;
    logic [4:0] sum;

    // Phase accumulator: step of rate in MHz, wraps at system MHz
    always_comb begin
        sum    = {1'b0, acc_q} + (slow ? 5'(adc_ctrl_pkg::SLOW_MHZ)
                                       : 5'(adc_ctrl_pkg::FAST_MHZ));
        acc_d  = sum[3:0];
        tick_d = 1'b0;
        if (!enable) begin
            acc_d = 4'h0;
        end else if (sum >= 5'(adc_ctrl_pkg::CLK_MHZ)) begin
            acc_d  = 4'(sum - 5'(adc_ctrl_pkg::CLK_MHZ));
            tick_d = 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_q  <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule // conv_tick_gen

// ---- rtl/result_correct.sv ----
// Offset and gain correction of a raw left-aligned sample.
// Assumes the caller registers the output; purely combinational.
`timescale 1ns/1ps
module result_correct (
    input  wire logic [15:0] raw,
    input  wire logic [15:0] offset,
    input  wire logic [15:0] gain,
    input  wire logic [2:0]  period,
    output logic      [15:0] value
);
    logic signed [16:0] sum;
    logic signed [33:0] prod;
    logic signed [18:0] scaled;
    logic        [15:0] clipped;

    // Offset first, then unsigned 1.15 gain, then clip and mask
    always_comb begin
        sum    = $signed({raw[15], raw}) + $signed({offset[15], offset});
        prod   = sum * $signed({1'b0, gain});
        scaled = prod[adc_ctrl_pkg::GAIN_FRAC +: 19];
        if (!scaled[18] && |scaled[17:15]) begin
            clipped = 16'h7fff;
        end else if (scaled[18] && !(&scaled[17:15])) begin
            clipped = 16'h8000;
        end else begin
            clipped = scaled[15:0];
        end
        value = clipped & adc_ctrl_pkg::resolution_mask(period);
    end

endmodule // result_correct

// ---- tb/adc_config_and_result_regs_bench.sv ----
// Self-checking bench for the converter control block: registers, selects,
// conversion lengths, correction and stop. Assumes one bus wait cycle.
`timescale 1ns/1ps
module adc_config_and_result_regs_bench;
    localparam int LIMIT = 20000;
    logic        clk;
    logic        reset;
    logic [31:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [15:0] raw_sample;
    logic        converter_run;
    logic        conv_clk_en;
    logic        sample_done;
    logic        slow_clock_select;
    logic [3:0]  positive_input_select;
    logic [3:0]  negative_input_select;
    logic        select_reserved;
    int          error_cnt;
    int          total_checks;
    int          cycles;
    logic [31:0] rd;
    int          tick_at_done;

    adc_ctrl u_adc_ctrl (
        .clk                   (clk),
        .reset                 (reset),
        .address               (address),
        .read                  (read),
        .write                 (write),
        .writedata             (writedata),
        .byteenable            (byteenable),
        .readdata              (readdata),
        .waitrequest           (waitrequest),
        .raw_sample            (raw_sample),
        .converter_run         (converter_run),
        .conv_clk_en           (conv_clk_en),
        .sample_done           (sample_done),
        .slow_clock_select     (slow_clock_select),
        .positive_input_select (positive_input_select),
        .negative_input_select (negative_input_select),
        .select_reserved       (select_reserved)
    );

    // Free-running 10 MHz clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            finish_test();
        end
    end

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bus write, held until waitrequest is sampled low
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [3:0] be);
        @(posedge clk);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        write      <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    // Bus read, data taken at the completing edge
    task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read    <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask

    // Configuration word from its fields
    function automatic logic [31:0] cfg(input logic [2:0] per,
        input logic [3:0] p, input logic [3:0] n, input logic slow,
        input logic en);
        adc_ctrl_pkg::config_t c;
        c = '0;
        c.period = per;
        c.positive_input_select = p;
        c.negative_input_select = n;
        c.slow_clock_select = slow;
        c.enable = en;
        return {16'h0000, c};
    endfunction

    // Offset, gain, clip, then keep the significant top bits
    function automatic logic [15:0] expect_res(input logic [15:0] raw,
        input logic [15:0] off, input logic [15:0] gain,
        input logic [2:0] per);
        logic signed [17:0] sum;
        logic signed [35:0] sh;
        logic        [15:0] v;
        sum = $signed({{2{raw[15]}}, raw}) + $signed({{2{off[15]}}, off});
        sh = (sum * $signed({1'b0, gain})) >>> 15;
        if (sh > 32767) v = 16'h7fff;
        else if (sh < -32768) v = 16'h8000;
        else v = sh[15:0];
        return v & (16'hffff << (9 - per));
    endfunction

    // Checks that no result comes during the settle time, then counts ticks to the first result
    task automatic first_conv(input int ticks);
        int tk;
        int early;
        early = 0;
        do @(posedge clk); while (converter_run !== 1'b1);
        repeat (adc_ctrl_pkg::SETTLE_CYC) begin
            @(posedge clk);
            if (sample_done !== 1'b0) early++;
        end
        check("settle passed", early, 0);
        next_conv(conv_clk_en === 1'b1, tk);
        check("first ticks", tk, ticks);
    endtask

    // Ticks up to the next result, c of them already owed to it; a tick
    // on the result edge opens the following conversion
    task automatic next_conv(input int c, output int tk);
        tk = c;
        forever begin
            @(posedge clk);
            if (sample_done === 1'b1 && tk > 0) break;
            if (conv_clk_en === 1'b1) tk++;
        end
        tick_at_done = (conv_clk_en === 1'b1);
    endtask

    // Reset values, read-only result, unmapped place, byte lanes
    task automatic test_registers;
        bus_read(adc_ctrl_pkg::RESULT_ADDR, rd);
        check("result reset", rd, 32'h0000_0000);
        bus_read(adc_ctrl_pkg::CONFIG_ADDR, rd);
        check("config reset", rd, 32'h0000_1800);
        bus_read(adc_ctrl_pkg::GAIN_ADDR, rd);
        check("gain reset", rd, 32'h0000_8000);
        bus_write(adc_ctrl_pkg::RESULT_ADDR, 32'hffff_ffff, 4'hf);
        bus_read(adc_ctrl_pkg::RESULT_ADDR, rd);
        check("result read only", rd, 32'h0000_0000);
        bus_write(32'h4000_e010, 32'hffff_ffff, 4'hf);
        bus_read(32'h4000_e010, rd);
        check("unmapped", rd, 32'h0000_0000);
        bus_write(adc_ctrl_pkg::OFFSET_ADDR, 32'h1234_abcd, 4'h1);
        bus_write(adc_ctrl_pkg::OFFSET_ADDR, 32'h0000_5500, 4'h2);
        bus_read(adc_ctrl_pkg::OFFSET_ADDR, rd);
        check("offset lanes", rd, 32'h0000_55cd);
        bus_write(adc_ctrl_pkg::OFFSET_ADDR, 32'h0000_0000, 4'hf);
        check("idle run", converter_run, 1'b0);
    endtask

    // Every select code on both fields, clock select bit
    task automatic test_selects;
        logic [3:0] c;
        logic       bad;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            bad = (c == 4'h6) || (c == 4'h7) || (c >= 4'hc);
            bus_write(adc_ctrl_pkg::CONFIG_ADDR, cfg(3'h0, c, 4'h0,
                      1'b0, 1'b0), 4'hf);
            @(posedge clk);
            check("pos select", positive_input_select, c);
            check("pos reserved", select_reserved, bad);
            bus_write(adc_ctrl_pkg::CONFIG_ADDR, cfg(3'h0, 4'h0, c,
                      c[0], 1'b0), 4'hf);
            @(posedge clk);
            check("neg select", negative_input_select, c);
            check("neg reserved", select_reserved, bad);
            check("slow select", slow_clock_select, c[0]);
            bus_read(adc_ctrl_pkg::CONFIG_ADDR, rd);
            check("config back", rd, cfg(3'h0, 4'h0, c, c[0], 1'b0));
        end
    endtask

    // Start, steady run, reconfigure, correction, slow clock
    task automatic test_convert;
        int tk;
        raw_sample <= 16'h5a5a;
        bus_write(adc_ctrl_pkg::CONFIG_ADDR, cfg(3'h0, 4'h1, 4'h2,
                  1'b0, 1'b1), 4'hf);
        first_conv(64);
        next_conv(tick_at_done, tk);
        check("steady ticks", tk, 32);
        bus_read(adc_ctrl_pkg::RESULT_ADDR, rd);
        check("first result", rd, {16'h0000, 16'h5a00});
        bus_write(adc_ctrl_pkg::CONFIG_ADDR, cfg(3'h0, 4'h9, 4'h2,
                  1'b0, 1'b1), 4'hf);
        next_conv(0, tk);
        check("changed ticks", tk, 64);
        next_conv(tick_at_done, tk);
        check("after change", tk, 32);
        bus_write(adc_ctrl_pkg::OFFSET_ADDR, 32'h0000_0400, 4'hf);
        bus_write(adc_ctrl_pkg::GAIN_ADDR, 32'h0000_4000, 4'hf);
        next_conv(0, tk);
        next_conv(tick_at_done, tk);
        bus_read(adc_ctrl_pkg::RESULT_ADDR, rd);
        check("corrected", rd, {16'h0000, expect_res(16'h5a5a, 16'h0400,
              16'h4000, 3'h0)});
        bus_write(adc_ctrl_pkg::CONFIG_ADDR, cfg(3'h0, 4'h9, 4'h2,
                  1'b1, 1'b1), 4'hf);
        tk = 0;
        repeat (200) begin
            @(posedge clk);
            if (conv_clk_en === 1'b1) tk++;
        end
        check("slow rate", tk >= 19 && tk <= 21, 1'b1);
    endtask

    // Stop holds the result; restart at a longer period
    task automatic test_stop;
        int          tk;
        logic [31:0] held;
        bus_read(adc_ctrl_pkg::RESULT_ADDR, held);
        bus_write(adc_ctrl_pkg::CONFIG_ADDR, cfg(3'h0, 4'h9, 4'h2,
                  1'b0, 1'b0), 4'hf);
        raw_sample <= 16'ha5a5;
        repeat (2) @(posedge clk);
        check("stopped", converter_run, 1'b0);
        tk = 0;
        repeat (300) begin
            @(posedge clk);
            if (sample_done === 1'b1) tk++;
        end
        check("no results", tk, 0);
        bus_read(adc_ctrl_pkg::RESULT_ADDR, rd);
        check("held result", rd, held);
        bus_write(adc_ctrl_pkg::CONFIG_ADDR, cfg(3'h1, 4'ha, 4'h8,
                  1'b0, 1'b1), 4'hf);
        first_conv(128);
        next_conv(tick_at_done, tk);
        check("period one", tk, 64);
        bus_read(adc_ctrl_pkg::RESULT_ADDR, rd);
        check("signed result", rd, {16'h0000, expect_res(16'ha5a5,
              16'h0400, 16'h4000, 3'h1)});
    endtask

    // Report and end the run
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        error_cnt = 0;
        total_checks = 0;
        cycles = 0;
        reset = 1'b1;
        address = 32'h0000_0000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        raw_sample = 16'h0000;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        test_registers();
        test_selects();
        test_convert();
        test_stop();
        finish_test();
    end
endmodule // adc_config_and_result_regs_bench
